// [bise_pkg.sv]
// constants, types and encodings for the branch/increment/or/shift execute block
package bise_pkg;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int ADDR_W = 7;
  localparam int JUMP_K_W = 11;
  localparam int LATCH_W = 8;
  // field positions inside the instruction word and the pc high latch
  localparam int OPC_MSB = 13;
  localparam int OPC_LSB = 8;
  localparam int DEST_BIT = 7;
  localparam int ADDR_MSB = 6;
  localparam int JUMP_OPC_LSB = 11;
  localparam int LATCH_HI_BIT = 4;
  localparam int LATCH_LO_BIT = 3;
  // opcode values
  localparam logic [2:0] OPC_JUMP = 3'h5;
  localparam logic [5:0] OPC_INCSZ = 6'h0F;
  localparam logic [5:0] OPC_INC = 6'h0A;
  localparam logic [5:0] OPC_ORLW = 6'h38;
  localparam logic [5:0] OPC_ORWF = 6'h04;
  localparam logic [5:0] OPC_SHL = 6'h35;
  // reset values and increment steps
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  typedef enum logic [2:0] {
    OP_NOP, OP_JUMP, OP_INCSZ, OP_INC, OP_ORLW, OP_ORWF, OP_SHL
  } bise_op_e;
  typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_DEAD} bise_state_e;
endpackage

// [bise_alu_if.sv]
// operand and result bundle between the sequencer and the datapath
`timescale 1ns/1ps
interface bise_alu_if;
  bise_pkg::bise_op_e op;
  logic [bise_pkg::DATA_W-1:0] work;
  logic [bise_pkg::DATA_W-1:0] file;
  logic [bise_pkg::DATA_W-1:0] lit;
  logic [bise_pkg::DATA_W-1:0] result;
  logic carry_out;
  logic upd_zero;
  logic upd_carry;
  logic has_dest;
  logic skip;
  modport seq (output op, output work, output file, output lit,
    input result, input carry_out, input upd_zero, input upd_carry,
    input has_dest, input skip);
  modport alu (input op, input work, input file, input lit,
    output result, output carry_out, output upd_zero, output upd_carry,
    output has_dest, output skip);
endinterface

// [bise_alu.sv]
// combinational datapath for increment, or and left shift
`timescale 1ns/1ps
module bise_alu (
  bise_alu_if.alu a
);
  wire [bise_pkg::DATA_W-1:0] inc_sum = a.file + bise_pkg::ONE;
  wire [bise_pkg::DATA_W-1:0] or_lit = a.work | a.lit;
  wire [bise_pkg::DATA_W-1:0] or_file = a.work | a.file;
  wire [bise_pkg::DATA_W-1:0] shl = {a.file[bise_pkg::DATA_W-2:0], 1'b0};
  wire is_inc = (a.op == bise_pkg::OP_INC) || (a.op == bise_pkg::OP_INCSZ);
  assign a.result = is_inc ? inc_sum :
                    (a.op == bise_pkg::OP_ORLW) ? or_lit :
                    (a.op == bise_pkg::OP_ORWF) ? or_file :
                    (a.op == bise_pkg::OP_SHL) ? shl : a.work;
  assign a.carry_out = a.file[bise_pkg::DATA_W-1];
  // incsz and jump leave zero alone
  assign a.upd_zero = (a.op == bise_pkg::OP_INC) || (a.op == bise_pkg::OP_ORLW) ||
                      (a.op == bise_pkg::OP_ORWF) || (a.op == bise_pkg::OP_SHL);
  assign a.upd_carry = (a.op == bise_pkg::OP_SHL);
  assign a.has_dest = is_inc || (a.op == bise_pkg::OP_ORWF) || (a.op == bise_pkg::OP_SHL);
  assign a.skip = (a.op == bise_pkg::OP_INCSZ) && (inc_sum == '0);
endmodule

// [bise_exec.sv]
// instruction sequencer: decode, pc update, register writeback and flags
`timescale 1ns/1ps
module bise_exec (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [bise_pkg::INSTR_W-1:0] instr,
  input wire logic [bise_pkg::LATCH_W-1:0] pc_high_latch,
  input wire logic [bise_pkg::DATA_W-1:0] file_rdata,
  output logic instr_ready,
  output logic [bise_pkg::PC_W-1:0] pc,
  output logic [bise_pkg::ADDR_W-1:0] file_addr,
  output logic [bise_pkg::DATA_W-1:0] file_wdata,
  output logic file_we,
  output logic [bise_pkg::DATA_W-1:0] work_reg,
  output logic zero_flag,
  output logic carry_flag,
  output logic skip_pulse,
  output logic illegal_pulse
);
  function automatic bise_pkg::bise_op_e decode(input logic [bise_pkg::INSTR_W-1:0] iw);
    logic [5:0] opc;
    opc = iw[bise_pkg::OPC_MSB:bise_pkg::OPC_LSB];
    if (iw[bise_pkg::OPC_MSB:bise_pkg::JUMP_OPC_LSB] == bise_pkg::OPC_JUMP) begin
      decode = bise_pkg::OP_JUMP;
    end else if (opc == bise_pkg::OPC_INCSZ) begin
      decode = bise_pkg::OP_INCSZ;
    end else if (opc == bise_pkg::OPC_INC) begin
      decode = bise_pkg::OP_INC;
    end else if (opc == bise_pkg::OPC_ORLW) begin
      decode = bise_pkg::OP_ORLW;
    end else if (opc == bise_pkg::OPC_ORWF) begin
      decode = bise_pkg::OP_ORWF;
    end else if (opc == bise_pkg::OPC_SHL) begin
      decode = bise_pkg::OP_SHL;
    end else begin
      decode = bise_pkg::OP_NOP;
    end
  endfunction

  bise_pkg::bise_state_e state_reg, state_next;
  bise_pkg::bise_op_e op_reg;
  logic dest_reg;
  logic [bise_pkg::DATA_W-1:0] lit_reg;
  logic [bise_pkg::JUMP_K_W-1:0] jump_k_reg;
  logic [bise_pkg::PC_W-1:0] pc_reg, pc_next;
  logic [bise_pkg::ADDR_W-1:0] addr_reg;
  logic [bise_pkg::DATA_W-1:0] work_next, wdata_reg;
  logic ready_reg, we_reg, we_next, zero_reg, zero_next, carry_reg, carry_next;
  logic skip_reg, illegal_reg;

  bise_alu_if alu_bus ();
  bise_alu u_alu (
    .a(alu_bus)
  );

  wire take = (state_reg == bise_pkg::ST_FETCH) && instr_valid;
  wire bise_pkg::bise_op_e op_dec = decode(instr);
  wire in_exec = (state_reg == bise_pkg::ST_EXEC);
  // d=0 selects the working register, d=1 the file register
  wire to_file = alu_bus.has_dest && dest_reg;
  wire to_work = (alu_bus.has_dest && !dest_reg) || (op_reg == bise_pkg::OP_ORLW);
  wire result_zero = (alu_bus.result == '0);
  wire [bise_pkg::PC_W-1:0] jump_target = {pc_high_latch[bise_pkg::LATCH_HI_BIT:
    bise_pkg::LATCH_LO_BIT], jump_k_reg};
  wire extra_slot = (op_reg == bise_pkg::OP_JUMP) || alu_bus.skip;

  assign alu_bus.op = op_reg;
  assign alu_bus.work = work_reg;
  assign alu_bus.file = file_rdata;
  assign alu_bus.lit = lit_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bise_pkg::ST_FETCH: begin
        if (instr_valid) begin
          state_next = bise_pkg::ST_EXEC;
        end
      end
      bise_pkg::ST_EXEC: begin
        state_next = extra_slot ? bise_pkg::ST_DEAD : bise_pkg::ST_FETCH;
      end
      bise_pkg::ST_DEAD: begin
        state_next = bise_pkg::ST_FETCH;
      end
    endcase
  end

  always_comb begin
    pc_next = pc_reg;
    if (take) begin
      pc_next = pc_reg + bise_pkg::PC_STEP;
    end else if (in_exec && op_reg == bise_pkg::OP_JUMP) begin
      pc_next = jump_target;
    end else if (in_exec && alu_bus.skip) begin
      // step past the instruction that the dead slot replaces
      pc_next = pc_reg + bise_pkg::PC_STEP;
    end
  end

  // jump and incsz never reach the flag updates
  assign work_next = (in_exec && to_work) ? alu_bus.result : work_reg;
  assign we_next = in_exec && to_file;
  assign zero_next = (in_exec && alu_bus.upd_zero) ? result_zero : zero_reg;
  assign carry_next = (in_exec && alu_bus.upd_carry) ? alu_bus.carry_out : carry_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= bise_pkg::ST_FETCH;
      pc_reg <= bise_pkg::PC_RESET;
      work_reg <= bise_pkg::WORK_RESET;
      zero_reg <= 1'b0;
      carry_reg <= 1'b0;
      we_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      work_reg <= work_next;
      zero_reg <= zero_next;
      carry_reg <= carry_next;
      we_reg <= we_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      op_reg <= bise_pkg::OP_NOP;
      dest_reg <= 1'b0;
      lit_reg <= '0;
      jump_k_reg <= '0;
      addr_reg <= '0;
    end else if (take) begin
      op_reg <= op_dec;
      dest_reg <= instr[bise_pkg::DEST_BIT];
      lit_reg <= instr[bise_pkg::DATA_W-1:0];
      jump_k_reg <= instr[bise_pkg::JUMP_K_W-1:0];
      addr_reg <= instr[bise_pkg::ADDR_MSB:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wdata_reg <= '0;
      skip_reg <= 1'b0;
      illegal_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      wdata_reg <= in_exec ? alu_bus.result : wdata_reg;
      skip_reg <= in_exec && alu_bus.skip;
      illegal_reg <= take && (op_dec == bise_pkg::OP_NOP);
      // ready is registered from the next state, so it is high while the current state is fetch, except the first cycle after reset
      ready_reg <= (state_next == bise_pkg::ST_FETCH);
    end
  end

  assign instr_ready = ready_reg;
  assign pc = pc_reg;
  assign file_addr = addr_reg;
  assign file_wdata = wdata_reg;
  assign file_we = we_reg;
  assign zero_flag = zero_reg;
  assign carry_flag = carry_reg;
  assign skip_pulse = skip_reg;
  assign illegal_pulse = illegal_reg;
endmodule

// [bise_exec_asserts.sv]
// port-level assertions for the execute block
`timescale 1ns/1ps
module bise_exec_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [7:0] pc_high_latch,
  input wire logic [7:0] file_rdata,
  input wire logic instr_ready,
  input wire logic [12:0] pc,
  input wire logic [6:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] work_reg,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic skip_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic take = instr_valid && instr_ready;
  wire logic [5:0] opc = instr[13:8];
  wire logic [1:0] latch_hi = pc_high_latch[4:3];
  wire logic [10:0] jk = instr[10:0];
  wire logic [7:0] lit = instr[7:0];
  wire logic dsel = instr[7];
  wire logic is_jump = instr[13:11] == 3'h5;
  wire logic is_byte = opc == 6'h0F || opc == 6'h0A || opc == 6'h04 || opc == 6'h35;
  sequence jump_s; take && is_jump; endsequence
  sequence hold_s; !instr_ready ##1 !instr_ready ##1 instr_ready; endsequence
  sequence incsz_s; take && opc == 6'h0F; endsequence
  sequence inc_s; take && opc == 6'h0A; endsequence
  sequence shift_s; take && opc == 6'h35; endsequence
  sequence orlw_s; take && opc == 6'h38; endsequence
  sequence orwf_s; take && opc == 6'h04; endsequence
  jump_target_a: assert property (jump_s |-> ##2
    pc == {$past(latch_hi), $past(jk, 2)}) else $error("jump target wrong");
  jump_cycles_a: assert property (jump_s |=> hold_s) else $error("jump length wrong");
  jump_flags_a: assert property (jump_s |-> ##2 zero_flag == $past(zero_flag, 2)
    && carry_flag == $past(carry_flag, 2)) else $error("jump touched flags");
  skip_zero_a: assert property (incsz_s |-> ##2
    skip_pulse == ($past(file_rdata) == 8'hFF) && zero_flag == $past(zero_flag, 2))
    else $error("skip wrong");
  inc_zero_a: assert property (inc_s |-> ##2
    zero_flag == ($past(file_rdata) == 8'hFF) && carry_flag == $past(carry_flag, 2))
    else $error("inc zero wrong");
  shift_carry_a: assert property (shift_s |-> ##2
    carry_flag == ($past(file_rdata) >= 8'h80) && zero_flag == ($past(file_rdata[6:0]) == 7'h00))
    else $error("shift flags wrong");
  or_literal_a: assert property (orlw_s |-> ##2
    work_reg == ($past(work_reg, 2) | $past(lit, 2)) && zero_flag == (work_reg == 8'h00))
    else $error("or literal wrong");
  or_file_a: assert property (orwf_s |-> ##2
    zero_flag == (($past(work_reg, 2) | $past(file_rdata)) == 8'h00))
    else $error("or file wrong");
  dest_select_a: assert property (take && is_byte |-> ##2 file_we == $past(dsel, 2))
    else $error("destination select wrong");
  file_addr_a: assert property (take && is_byte |=> file_addr == $past(instr[6:0]))
    else $error("file address wrong");
endmodule
bind bise_exec bise_exec_asserts chk_u (.*);

// [tb.sv]
// randomised self-checking bench for the execute block
`timescale 1ns/1ps
module tb;
  logic clk = 0, reset = 1, instr_valid = 0;
  logic [13:0] instr = 0;
  logic [7:0] pc_high_latch = 0, file_rdata = 0, file_wdata, work_reg, ew;
  logic instr_ready, file_we, zero_flag, carry_flag, skip_pulse, illegal_pulse, ez, ec;
  logic [12:0] pc, epc;
  logic [6:0] file_addr;
  logic [5:0] ops [6] = '{6'h0F, 6'h0A, 6'h38, 6'h04, 6'h35, 6'h28};
  logic [13:0] w;
  int num_errors = 0, checks_done = 0;
  bise_exec dut_u (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
    .pc_high_latch(pc_high_latch), .file_rdata(file_rdata), .instr_ready(instr_ready),
    .pc(pc), .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
    .work_reg(work_reg), .zero_flag(zero_flag), .carry_flag(carry_flag),
    .skip_pulse(skip_pulse), .illegal_pulse(illegal_pulse));
  always #2.5 clk = ~clk;
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one instruction: present when ready, feed file data in the exec slot, compare results
  task run(input logic [13:0] iw, input logic [7:0] f, input logic [7:0] lat);
    logic [5:0] o;
    logic [7:0] r;
    logic bo, we, sk, il, jp;
    int n;
    o = iw[13:8];
    bo = o inside {6'h0F, 6'h0A, 6'h04, 6'h35};
    jp = iw[13:11] == 3'h5;
    {we, sk, il} = 3'b000;
    r = ew;
    n = 0;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    // a ready that never comes is a failure, not a silent skip
    if (n >= 20) chk("ready_wait", instr_ready, 1);
    instr_valid = 1;
    instr = iw;
    pc_high_latch = lat;
    @(negedge clk);
    instr_valid = 0;
    file_rdata = f;
    epc = epc + 1;
    chk("pc_step", pc, epc);
    if (bo) chk("file_addr", file_addr, iw[6:0]);
    if (jp) epc = {lat[4:3], iw[10:0]};
    else case (o)
      6'h0F: begin r = f + 1; sk = r == 0; end
      6'h0A: begin r = f + 1; ez = r == 0; end
      6'h38: begin r = ew | iw[7:0]; ez = r == 0; end
      6'h04: begin r = ew | f; ez = r == 0; end
      6'h35: begin r = {f[6:0], 1'b0}; ec = f[7]; ez = r == 0; end
      default: il = 1;
    endcase
    if (bo && iw[7]) we = 1;
    else if (bo || o == 6'h38) ew = r;
    // the illegal pulse stands in the exec slot, one cycle ahead of the results
    chk("illegal", illegal_pulse, il);
    if (sk) epc = epc + 1;
    @(negedge clk);
    chk("work_reg", work_reg, ew);
    chk("flags", {zero_flag, carry_flag}, {ez, ec});
    chk("pc", pc, epc);
    chk("pulses", {file_we, skip_pulse, illegal_pulse}, {we, sk, 1'b0});
    if (we) chk("file_wdata", file_wdata, r);
    if (jp || sk) begin
      chk("dead_slot", instr_ready, 0);
      @(negedge clk);
    end
    chk("ready", instr_ready, 1);
  endtask
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'h95f5_6467));
    repeat (20) @(negedge clk);
    reset = 0;
    {ew, ez, ec, epc} = '0;
    chk("reset", {pc, work_reg, zero_flag, carry_flag, file_we, skip_pulse}, 0);
    run({6'h0F, 1'b0, 7'h12}, 8'hFF, 0);
    run({6'h0F, 1'b1, 7'h7F}, 8'h41, 0);
    run({6'h0A, 1'b0, 7'h00}, 8'hFF, 0);
    run({6'h35, 1'b0, 7'h05}, 8'h80, 0);
    run({6'h38, 8'h00}, 0, 0);
    run({6'h04, 1'b1, 7'h33}, 8'h5A, 0);
    run({3'h5, 11'h7FF}, 0, 8'h18);
    run({6'h3F, 8'hA5}, 0, 0);
    $display("corner test done");
    repeat (300) begin
      w = {ops[$urandom % 6], 8'($urandom)};
      if (w[13:11] == 3'h5) w[10:8] = 3'($urandom);
      run(w, 8'($urandom), 8'($urandom));
    end
    $display("random test done");
    conclude();
  end
endmodule
